// >>> hw/feat_cfg.svh
// feature register bank constants: addresses, bit positions, defaults
// included by the bank module and the bench top
`ifndef FEAT_CFG_SVH
`define FEAT_CFG_SVH
`define ADDR_LOCK       8'hA0
`define ADDR_OPT        8'hB0
`define ADDR_STAT       8'hC0
`define ADDR_THRESH     8'h10
`define OP_SET_FEATURE  8'h1F
`define OP_GET_FEATURE  8'h0F
`define OP_WRITE_EN     8'h06
`define OP_WRITE_DIS    8'h04
`define OP_PROTECT_EXE  8'h2A
`define LOCK_WD_BIT     7
`define LOCK_RANGE_HI   5
`define LOCK_RANGE_LO   3
`define LOCK_WMASK      8'hB8
`define OPT_WMASK       8'h57
`define LOCK_DEFAULT    8'h38
`define OPT_DEFAULT     8'h12
`define THRESH_WMASK    8'hF0
`define THRESH_DEFAULT  8'h00
`define OPT_IDR_BIT     6
`define OPT_ECC_BIT     4
`define OPT_PRT_BIT     2
`define OPT_HSE_BIT     1
`define OPT_HOLD_BIT    0
`define ECC_NONE        2'h0
`define ECC_FIX_LOW     2'h1
`define ECC_UNFIXABLE   2'h2
`define ECC_FIX_HIGH    2'h3
`endif

// >>> hw/feat_pkg.sv
// types shared by the feature register bank
// constants live in feat_cfg.svh
package feat_pkg;
  typedef enum logic [1:0]
  {
    ST_OPCODE = 2'b00,
    ST_ADDR   = 2'b01,
    ST_DATA   = 2'b10,
    ST_IGNORE = 2'b11
  } link_state_t;
endpackage

// >>> hw/feat_regs.sv
// feature/status register bank of a serial nand device, spi mode 0
// assumes sck, cs and mosi come from another domain; array engine on clk_i
`timescale 1ns/100ps
`include "feat_cfg.svh"
module feat_regs
  import feat_pkg::*;
(
  input  wire logic       clk_i,             // system clock 100 MHz
  input  wire logic       resetn_i,          // power-on reset, low active
  input  wire logic       sck_i,             // serial clock from host
  input  wire logic       cs_n_i,            // chip select, low active
  input  wire logic       mosi_i,            // serial data in
  input  wire logic       wp_n_i,            // write protect pin, low active
  input  wire logic       busy_i,            // array engine busy
  input  wire logic       result_valid_i,    // engine result strobe
  input  wire logic       result_prog_i,     // result is program/protect
  input  wire logic       result_erase_i,    // result is erase
  input  wire logic       result_fail_i,     // operation failed
  input  wire logic       ecc_valid_i,       // page read ecc strobe
  input  wire logic       ecc_uncorr_i,      // uncorrectable flips
  input  wire logic [3:0] ecc_flips_i,       // corrected flip count
  output logic            miso_o,            // serial data out
  output logic            miso_oe_n_o,       // miso drive enable, low
  output logic [7:0]      opcode_o,          // last opcode taken
  output logic            opcode_valid_o,    // pulse: opcode taken
  output logic            id_page_read_select_o,   // id read mode
  output logic            ecc_enable_o,            // internal ecc on
  output logic            protection_arm_o,        // option byte prt bit
  output logic            fast_page_read_enable_o, // high speed read
  output logic            hold_disable_o,          // hold function off
  output logic [2:0]      lock_range_o,            // locked region code
  output logic            write_permit_latch_o     // write enable latch
);

  logic [2:0]  sck_sync_reg;
  logic [1:0]  cs_sync_reg;
  logic [1:0]  mosi_sync_reg;
  logic [1:0]  wp_sync_reg;
  logic        sck_prev_reg;
  logic        cs_prev_reg;
  link_state_t state_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  data_reg;
  logic        set_pending_reg;
  logic        get_active_reg;
  logic [7:0]  out_byte_reg;
  logic [2:0]  out_cnt_reg;
  logic [7:0]  lock_reg;
  logic [7:0]  opt_reg;
  logic [7:0]  thresh_reg;
  logic [1:0]  ecc_stat_reg;
  logic        prog_fail_reg;
  logic        erase_fail_reg;
  logic        wel_reg;
  logic        busy_reg;

  logic        sck_rise;
  logic        sck_fall;
  logic        cs_low;
  logic        cs_rise;
  logic        byte_done;
  logic [7:0]  byte_in;
  logic [7:0]  rd_byte;

  // bit 0 is the first stage; logic reads only the last stage of each
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sck_sync_reg  <= 3'h0;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      wp_sync_reg   <= 2'h3;
      sck_prev_reg  <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end
    else
    begin
      sck_sync_reg  <= {sck_sync_reg[1:0], sck_i};
      cs_sync_reg   <= {cs_sync_reg[0], cs_n_i};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_i};
      wp_sync_reg   <= {wp_sync_reg[0], wp_n_i};
      sck_prev_reg  <= sck_sync_reg[2];
      cs_prev_reg   <= cs_sync_reg[1];
    end
  end

  assign sck_rise  = sck_sync_reg[2] & ~sck_prev_reg;
  assign sck_fall  = ~sck_sync_reg[2] & sck_prev_reg;
  assign cs_low    = ~cs_sync_reg[1];
  assign cs_rise   = cs_sync_reg[1] & ~cs_prev_reg;
  assign byte_in   = {shift_reg[6:0], mosi_sync_reg[1]};
  assign byte_done = cs_low & sck_rise & (bit_cnt_reg == 3'h7);

  // read value of an addressed feature byte, reserved bits forced to zero
  function automatic logic [7:0] feat_read(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr == `ADDR_LOCK)
      val = lock_reg & `LOCK_WMASK;
    else if (addr == `ADDR_OPT)
      val = opt_reg & `OPT_WMASK;
    else if (addr == `ADDR_STAT)
      val = {2'h0, ecc_stat_reg, prog_fail_reg,
             erase_fail_reg, wel_reg, busy_reg};
    else if (addr == `ADDR_THRESH)
      val = thresh_reg & `THRESH_WMASK;
    return val;
  endfunction

  // a process, not an assign, so register reads inside the function wake it
  always_comb
    rd_byte = feat_read(addr_reg);

  // command framing over the serial link
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg       <= ST_OPCODE;
      bit_cnt_reg     <= 3'h0;
      shift_reg       <= 8'h00;
      addr_reg        <= 8'h00;
      data_reg        <= 8'h00;
      set_pending_reg <= 1'b0;
      get_active_reg  <= 1'b0;
      opcode_o        <= 8'h00;
      opcode_valid_o  <= 1'b0;
    end
    else
    begin
      opcode_valid_o <= 1'b0;
      if (!cs_low)
      begin
        state_reg      <= ST_OPCODE;
        bit_cnt_reg    <= 3'h0;
        get_active_reg <= 1'b0;
        if (cs_rise)
          set_pending_reg <= 1'b0;
      end
      else if (sck_rise)
      begin
        shift_reg   <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_done)
        begin
          case (state_reg)
            ST_OPCODE:
            begin
              opcode_o       <= byte_in;
              opcode_valid_o <= 1'b1;
              if (byte_in == `OP_SET_FEATURE ||
                  byte_in == `OP_GET_FEATURE)
                state_reg <= ST_ADDR;
              else
                state_reg <= ST_IGNORE;
            end
            ST_ADDR:
            begin
              addr_reg <= byte_in;
              if (opcode_o == `OP_GET_FEATURE)
              begin
                get_active_reg <= 1'b1;
                state_reg      <= ST_IGNORE;
              end
              else
                state_reg <= ST_DATA;
            end
            ST_DATA:
            begin
              data_reg        <= byte_in;
              set_pending_reg <= 1'b1;
              state_reg       <= ST_IGNORE;
            end
            default:
              state_reg <= ST_IGNORE;
          endcase
        end
      end
    end
  end

  // output shifter: reload each byte so live status is seen every repeat
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      out_byte_reg <= 8'h00;
      out_cnt_reg  <= 3'h0;
      miso_o       <= 1'b0;
      miso_oe_n_o  <= 1'b1;
    end
    else if (!get_active_reg)
    begin
      out_cnt_reg <= 3'h0;
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end
    else if (sck_fall)
    begin
      miso_oe_n_o <= 1'b0;
      if (out_cnt_reg == 3'h0)
      begin
        out_byte_reg <= {rd_byte[6:0], 1'b0};
        miso_o       <= rd_byte[7];
      end
      else
      begin
        out_byte_reg <= {out_byte_reg[6:0], 1'b0};
        miso_o       <= out_byte_reg[7];
      end
      out_cnt_reg <= out_cnt_reg + 3'h1;
    end
  end

  // feature bytes, written on chip select rise; reset commands leave them
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lock_reg   <= `LOCK_DEFAULT;
      opt_reg    <= `OPT_DEFAULT;
      thresh_reg <= `THRESH_DEFAULT;
    end
    else if (cs_rise && set_pending_reg)
    begin
      if (addr_reg == `ADDR_LOCK)
      begin
        if (!(!wp_sync_reg[1] && lock_reg[`LOCK_WD_BIT]))
          lock_reg <= data_reg & `LOCK_WMASK;
      end
      else if (addr_reg == `ADDR_OPT)
        opt_reg <= data_reg & `OPT_WMASK;
      else if (addr_reg == `ADDR_THRESH)
        thresh_reg <= data_reg & `THRESH_WMASK;
    end
  end

  // status bits; a new result wins over the clear by an accepted command
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ecc_stat_reg   <= `ECC_NONE;
      prog_fail_reg  <= 1'b0;
      erase_fail_reg <= 1'b0;
      wel_reg        <= 1'b0;
      busy_reg       <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_i;
      if (result_valid_i && result_prog_i)
        prog_fail_reg <= result_fail_i;
      else if (opcode_valid_o && opcode_o != `OP_GET_FEATURE)
        prog_fail_reg <= 1'b0;
      if (result_valid_i && result_erase_i)
        erase_fail_reg <= result_fail_i;
      else if (opcode_valid_o && opcode_o != `OP_GET_FEATURE)
        erase_fail_reg <= 1'b0;
      if (ecc_valid_i)
      begin
        if (ecc_uncorr_i)
          ecc_stat_reg <= `ECC_UNFIXABLE;
        else if (ecc_flips_i == 4'h0)
          ecc_stat_reg <= `ECC_NONE;
        else if (ecc_flips_i >= thresh_reg[7:4])
          ecc_stat_reg <= `ECC_FIX_HIGH;
        else
          ecc_stat_reg <= `ECC_FIX_LOW;
      end
      if (opcode_valid_o && opcode_o == `OP_WRITE_EN)
        wel_reg <= 1'b1;
      else if (opcode_valid_o && opcode_o == `OP_WRITE_DIS)
        wel_reg <= 1'b0;
    end
  end

  // config outputs registered; quad loads need hold off, host's duty
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      id_page_read_select_o   <= 1'b0;
      ecc_enable_o            <= 1'b1;
      protection_arm_o        <= 1'b0;
      fast_page_read_enable_o <= 1'b1;
      hold_disable_o          <= 1'b0;
      lock_range_o            <= 3'h7;
      write_permit_latch_o    <= 1'b0;
    end
    else
    begin
      id_page_read_select_o   <= opt_reg[`OPT_IDR_BIT];
      ecc_enable_o            <= opt_reg[`OPT_ECC_BIT];
      protection_arm_o        <= opt_reg[`OPT_PRT_BIT];
      fast_page_read_enable_o <= opt_reg[`OPT_HSE_BIT];
      hold_disable_o          <= opt_reg[`OPT_HOLD_BIT];
      lock_range_o <= lock_reg[`LOCK_RANGE_HI:`LOCK_RANGE_LO];
      write_permit_latch_o    <= wel_reg;
    end
  end

endmodule

// >>> verification/feat_regs_sva.sv
// checker for the feature register bank, watching its ports only
// assumes it is bound to feat_regs from the bench top file
`timescale 1ns/100ps
module feat_regs_sva
(
  input wire logic       clk_i,                   // clock
  input wire logic       resetn_i,                // reset, low active
  input wire logic       cs_n_i,                  // chip select
  input wire logic       miso_oe_n_o,             // drive enable, low
  input wire logic [7:0] opcode_o,                // last opcode
  input wire logic       opcode_valid_o,          // opcode pulse
  input wire logic [2:0] lock_range_o,            // lock code
  input wire logic       ecc_enable_o,            // ecc on
  input wire logic       fast_page_read_enable_o, // fast read
  input wire logic       hold_disable_o,          // hold off
  input wire logic       write_permit_latch_o     // write latch
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  oe_release_a: assert property (
    cs_n_i [*8] |-> miso_oe_n_o)
    else $error("miso drive left on after select high");
  oe_start_a: assert property (
    $fell(miso_oe_n_o) |-> !cs_n_i && opcode_o == 8'h0F)
    else $error("miso driven outside a get feature frame");
  oe_hold_a: assert property (
    !miso_oe_n_o && !cs_n_i |=> !miso_oe_n_o)
    else $error("miso drive dropped while selected");
  wel_set_a: assert property (
    opcode_valid_o && opcode_o == 8'h06 |-> ##[0:3] write_permit_latch_o)
    else $error("write latch not set");
  wel_clr_a: assert property (
    opcode_valid_o && opcode_o == 8'h04 |-> ##[0:3] !write_permit_latch_o)
    else $error("write latch not cleared");
  wel_cause_a: assert property (
    $changed(write_permit_latch_o) |-> opcode_o inside {8'h06, 8'h04})
    else $error("write latch moved by another opcode");
  cfg_quiet_a: assert property (
    $changed({lock_range_o, hold_disable_o}) |-> cs_n_i)
    else $error("settings changed inside a frame");
  reset_val_a: assert property (
    $rose(resetn_i) |-> lock_range_o == 3'h7 && ecc_enable_o &&
      fast_page_read_enable_o && !hold_disable_o)
    else $error("wrong settings after reset");
  valid_pulse_a: assert property (
    opcode_valid_o |-> !cs_n_i ##1 !opcode_valid_o)
    else $error("opcode pulse outside frame or too long");
endmodule

// >>> verification/spi_host_model.sv
// serial host model: mode 0 frames of written bytes then read bits
// assumes the bench clock; sck half period is 8 clock cycles
`timescale 1ns/100ps
module spi_host_model
(
  input  wire logic clk_i,  // bench clock
  input  wire logic miso_i, // device data out
  output logic      sck_o,  // serial clock, idle low
  output logic      cs_n_o, // chip select, low active
  output logic      mosi_o  // serial data
);
  initial
  begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic frame(input logic [23:0] tx, input int nw,
                       input int nr, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (i = 0; i < nw * 8 + nr; i++)
    begin
      // mode 0: data moves with sck fall, msb first; filler while reading
      mosi_o <= (i < nw * 8) ? tx[23 - i] : i[0];
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b1;
      if (i >= nw * 8)
        rx = {rx[14:0], miso_i};
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    // gap lets the write land before the next frame
    repeat (12) @(posedge clk_i);
  endtask
endmodule

// >>> verification/tb_top.sv
// bench top: feature register bank driven by the serial host model
// assumes 100 MHz clock; engine strobes driven here
`timescale 1ns/100ps
`include "feat_cfg.svh"
module tb_top;
  logic        clk_i = 1'b0;
  logic        resetn_i, wp_n_i, busy_i, rv, rp, re, rf, ev, eu;
  logic [3:0]  ef;
  logic [15:0] rx;
  logic [15:0] opts;
  logic [7:0]  opc;
  logic [2:0]  lock_range_o;
  logic        sck, cs_n, mosi, miso, oe_n, miso_w, opv, id, ecc, prt, fast_page_read_enable;
  logic        hold, write_permit_latch;
  int          errors = 0, samples_checked = 0, cycles = 0, i;
  always #5 clk_i = ~clk_i;
  // released line has no pull: it shows the inverse of miso, which is held low then
  assign miso_w = oe_n ? ~miso : miso;
  assign opts   = {11'h000, id, ecc, prt, fast_page_read_enable, hold};
  spi_host_model host (.clk_i(clk_i), .miso_i(miso_w), .sck_o(sck),
    .cs_n_o(cs_n), .mosi_o(mosi));
  feat_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck),
    .cs_n_i(cs_n), .mosi_i(mosi), .wp_n_i(wp_n_i), .busy_i(busy_i),
    .result_valid_i(rv), .result_prog_i(rp), .result_erase_i(re),
    .result_fail_i(rf), .ecc_valid_i(ev), .ecc_uncorr_i(eu),
    .ecc_flips_i(ef), .miso_o(miso), .miso_oe_n_o(oe_n), .opcode_o(opc),
    .opcode_valid_o(opv), .id_page_read_select_o(id), .ecc_enable_o(ecc),
    .protection_arm_o(prt), .fast_page_read_enable_o(fast_page_read_enable),
    .hold_disable_o(hold), .lock_range_o(lock_range_o),
    .write_permit_latch_o(write_permit_latch));
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    host.frame({8'h1F, a, d}, 3, 0, rx);
  endtask
  task automatic getf(input logic [7:0] a, input logic [7:0] exp);
    host.frame({8'h0F, a, 8'h00}, 2, 16, rx);
    check(rx, {exp, exp});
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 16'h0000}, 1, 0, rx);
  endtask
  task automatic eng(input logic p, input logic e, input logic f);
    @(posedge clk_i);
    {rv, rp, re, rf} <= {1'b1, p, e, f};
    @(posedge clk_i);
    rv <= 1'b0;
  endtask
  task automatic eccr(input logic u, input logic [3:0] f);
    @(posedge clk_i);
    {ev, eu, ef} <= {1'b1, u, f};
    @(posedge clk_i);
    ev <= 1'b0;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    {resetn_i, busy_i, rv, rp, re, rf, ev, eu, ef} = '0;
    wp_n_i = 1'b1;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    getf(`ADDR_LOCK, `LOCK_DEFAULT);
    getf(`ADDR_OPT, `OPT_DEFAULT);
    getf(`ADDR_STAT, 8'h00);
    getf(`ADDR_THRESH, 8'h00);
    $display("defaults test done");
    setf(`ADDR_OPT, 8'hFF);
    cmd(8'h32);
    getf(`ADDR_OPT, 8'h57);
    check(opts, 16'h001F);
    cmd(8'hFF);
    getf(`ADDR_OPT, 8'h57);
    setf(`ADDR_OPT, 8'h00);
    check(opts, 16'h0000);
    $display("option test done");
    for (i = 0; i < 8; i++)
    begin
      setf(`ADDR_LOCK, {2'b00, i[2:0], 3'b000});
      check({13'h0000, lock_range_o}, i[15:0]);
    end
    setf(`ADDR_LOCK, 8'hFF);
    getf(`ADDR_LOCK, 8'hB8);
    wp_n_i <= 1'b0;
    setf(`ADDR_LOCK, 8'h00);
    getf(`ADDR_LOCK, 8'hB8);
    wp_n_i <= 1'b1;
    setf(`ADDR_LOCK, 8'h00);
    getf(`ADDR_LOCK, 8'h00);
    wp_n_i <= 1'b0;
    setf(`ADDR_LOCK, 8'h18);
    getf(`ADDR_LOCK, 8'h18);
    wp_n_i <= 1'b1;
    $display("lock test done");
    cmd(`OP_WRITE_EN);
    getf(`ADDR_STAT, 8'h02);
    setf(`ADDR_STAT, 8'h00);
    getf(`ADDR_STAT, 8'h02);
    cmd(`OP_WRITE_DIS);
    eng(1'b1, 1'b0, 1'b1);
    getf(`ADDR_STAT, 8'h08);
    eng(1'b0, 1'b1, 1'b1);
    getf(`ADDR_STAT, 8'h0C);
    cmd(`OP_WRITE_DIS);
    getf(`ADDR_STAT, 8'h00);
    eng(1'b1, 1'b0, 1'b1);
    eng(1'b0, 1'b1, 1'b1);
    eng(1'b1, 1'b0, 1'b0);
    getf(`ADDR_STAT, 8'h04);
    eng(1'b0, 1'b1, 1'b0);
    getf(`ADDR_STAT, 8'h00);
    $display("status test done");
    setf(`ADDR_THRESH, 8'h3F);
    getf(`ADDR_THRESH, 8'h30);
    eccr(1'b0, 4'h2);
    getf(`ADDR_STAT, 8'h10);
    eccr(1'b0, 4'h3);
    getf(`ADDR_STAT, 8'h30);
    eccr(1'b1, 4'h0);
    getf(`ADDR_STAT, 8'h20);
    eccr(1'b0, 4'h0);
    getf(`ADDR_STAT, 8'h00);
    $display("ecc test done");
    busy_i <= 1'b1;
    fork
      host.frame({8'h0F, `ADDR_STAT, 8'h00}, 2, 16, rx);
      begin
        // drop busy during the first read byte, before the repeat reloads it
        repeat (330) @(posedge clk_i);
        busy_i <= 1'b0;
      end
    join
    check(rx, 16'h0100);
    $display("busy test done");
    resetn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    getf(`ADDR_LOCK, `LOCK_DEFAULT);
    getf(`ADDR_OPT, `OPT_DEFAULT);
    $display("reset test done");
    test_done();
  end
endmodule
bind feat_regs feat_regs_sva chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .cs_n_i(cs_n_i), .miso_oe_n_o(miso_oe_n_o), .opcode_o(opcode_o),
  .opcode_valid_o(opcode_valid_o), .lock_range_o(lock_range_o),
  .ecc_enable_o(ecc_enable_o), .hold_disable_o(hold_disable_o),
  .fast_page_read_enable_o(fast_page_read_enable_o),
  .write_permit_latch_o(write_permit_latch_o));
